// [src/umr_report_ep.sv]
// interrupt IN report endpoint with motion accumulation
// ==========================================================
// Overview of operation
// [RULE1] idle rate accepted in any state, used only once configured
// [RULE2] vendor test write is 40 01 00 00 addr data 00 00, any state
// [RULE3] host keeps vendor test address within 0x00 to 0x3F
// [RULE4] poll ignored unless configured; then NAK if empty, else report
// [RULE5] endpoint stalls only while its halt bit is set
// [RULE6] host polls at least every 10 frames, may poll continuously
// [RULE7] no report is produced outside the configured state
// [RULE8] empty buffer takes any motion or button change at once
// [RULE9] motion arriving while buffer full is summed per axis
// [RULE10] emptying loads the sums into the buffer, then sums restart; the code keeps the excess beyond the saturated report values as new sums
// [RULE11] button state loaded into an empty buffer is kept as last sent
// [RULE12] button changes are not acted on while buffer is full
// [RULE13] on emptying, changed buttons are loaded and copy updated
// [RULE14] buttons are debounced before use
// [RULE15] with wheel: button byte, X, Y, wheel, four bytes
// [RULE16] without wheel: button byte, X, Y, three bytes
// [RULE17] status, configuration and interface replies give one byte at zero length
// [RULE18] idle rate byte is the repeat period in 4 ms units
// [RULE19] idle rate starts at zero, reports only on change
// [RULE20] sums are signed and saturate to 8 bits in the report
// [RULE21] buffer empties only on host acknowledge of a sent report; the code also empties it whenever the device is not configured
`timescale 1ns/1ps
`default_nettype none
module umr_report_ep
  import umr_pkg::*;
#(
  parameter int ACC_W = 12,
  parameter int IDLE_UNIT = IDLE_UNIT_CYC,
  parameter int DEB = DEB_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wheel_present,
  input wire umr_dev_state_t dev_state,
  input wire logic setup_valid,
  input wire umr_setup_t setup,
  input wire umr_motion_t motion,
  input wire logic [BTN_W-1:0] buttons_raw,
  input wire logic report_endpoint_poll,
  input wire logic host_ack,
  output logic resp_valid,
  output umr_resp_t resp_kind,
  output umr_report_t report,
  output logic [2:0] report_len,
  output logic report_pending,
  output logic report_endpoint_halt,
  output logic [7:0] idle_rate,
  output umr_vend_wr_t vend_wr,
  output logic reply_len_valid,
  output logic [15:0] reply_len
);
  localparam int UW = $clog2(IDLE_UNIT + 1);
  localparam logic [UW-1:0] UNIT_LAST = UW'(IDLE_UNIT - 1);

  // ==========================================================
  // saturating arithmetic
  function automatic logic [ACC_W-1:0] add_sat(input logic [ACC_W-1:0] a, input logic [7:0] d);
    logic [ACC_W:0] s;
    s = {a[ACC_W-1], a} + {{(ACC_W-7){d[7]}}, d};
    if (s[ACC_W] != s[ACC_W-1]) begin
      add_sat = s[ACC_W] ? {1'b1, {(ACC_W-1){1'b0}}} : {1'b0, {(ACC_W-1){1'b1}}};
    end else begin
      add_sat = s[ACC_W-1:0];
    end
  endfunction

  function automatic logic [7:0] sat8(input logic [ACC_W-1:0] v);
    if ((&v[ACC_W-1:7]) || !(|v[ACC_W-1:7])) begin
      sat8 = v[7:0];
    end else begin
      sat8 = v[ACC_W-1] ? SAT_NEG : SAT_POS;
    end
  endfunction

  function automatic logic [ACC_W-1:0] residue(input logic [ACC_W-1:0] v);
    logic [7:0] r;
    r = sat8(v);
    residue = v - {{(ACC_W-8){r[7]}}, r};
  endfunction

  // ==========================================================
  // debounced buttons
  logic [BTN_W-1:0] btn_deb;
  umr_debounce #(.W(BTN_W), .CNT(DEB)) u_umr_debounce (
    .mclk(mclk),
    .rst_n(rst_n),
    .raw(buttons_raw),
    .stable(btn_deb)
  );

  // ==========================================================
  // setup decode
  logic cfg, is_vendor, is_idle, is_halt_ep, report_endpoint_halt_set, halt_clr;
  logic is_status, is_config, is_iface;
  logic [15:0] wlen;
  assign cfg = (dev_state == DS_CONFIGURED);
  assign wlen = {setup.len_hi, setup.len_lo};
  assign is_vendor = setup_valid && setup.bm_req == RT_VENDOR_OUT && setup.b_req == RQ_VENDOR_TEST
                     && setup.val_lo == 8'h00 && setup.val_hi == 8'h00 && wlen == 16'h0000;
  assign is_idle = setup_valid && setup.bm_req == RT_CLASS_IF_OUT && setup.b_req == RQ_SET_IDLE;
  assign is_halt_ep = setup_valid && setup.bm_req == RT_STD_EP_OUT && setup.val_lo == FEAT_EP_HALT
                      && setup.idx_lo == EP_REPORT_IN;
  assign report_endpoint_halt_set = is_halt_ep && setup.b_req == RQ_SET_FEATURE;
  assign halt_clr = is_halt_ep && setup.b_req == RQ_CLEAR_FEATURE;
  assign is_status = setup_valid && setup.b_req == RQ_GET_STATUS
                     && (setup.bm_req == RT_STD_DEV_IN || setup.bm_req == RT_STD_IF_IN
                         || setup.bm_req == RT_STD_EP_IN);
  assign is_config = setup_valid && setup.bm_req == RT_STD_DEV_IN && setup.b_req == RQ_GET_CONFIG;
  assign is_iface = setup_valid && setup.bm_req == RT_STD_IF_IN && setup.b_req == RQ_GET_IFACE;

  // ==========================================================
  // control state
  logic halt_r, halt_nxt;
  logic [7:0] idle_r, idle_nxt;
  umr_vend_wr_t vend_r, vend_nxt;
  logic rlv_r, rlv_nxt;
  logic [15:0] rl_r, rl_nxt;
  logic [15:0] nat_len;

  always_comb begin
    halt_nxt = halt_r;
    idle_nxt = idle_r;
    vend_nxt = '0;
    rlv_nxt = 1'b0;
    rl_nxt = rl_r;
    nat_len = is_status ? STATUS_LEN : (is_config ? CONFIG_LEN : IFACE_LEN);
    if (report_endpoint_halt_set) begin
      halt_nxt = 1'b1; // [RULE5]
    end else if (halt_clr) begin
      halt_nxt = 1'b0;
    end
    if (is_idle) begin
      idle_nxt = setup.val_hi; // [RULE1] [RULE18]
    end
    if (is_vendor) begin
      vend_nxt = {1'b1, setup.idx_lo, setup.idx_hi}; // [RULE2]
    end
    if (is_status || is_config || is_iface) begin
      rlv_nxt = 1'b1;
      rl_nxt = (wlen == 16'h0000) ? MIN_REPLY_LEN : ((wlen < nat_len) ? wlen : nat_len); // [RULE17]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
      idle_r <= IDLE_RATE_RST; // [RULE19]
      vend_r <= '0;
      rlv_r <= 1'b0;
      rl_r <= 16'h0000;
    end else begin
      halt_r <= halt_nxt;
      idle_r <= idle_nxt;
      vend_r <= vend_nxt;
      rlv_r <= rlv_nxt;
      rl_r <= rl_nxt;
    end
  end

  // ==========================================================
  // report buffer, accumulators, idle timer, poll answer
  umr_ep_state_t ep_r, ep_nxt;
  logic full_r, full_nxt;
  umr_report_t rpt_r, rpt_nxt;
  logic [2:0] len_r, len_nxt;
  logic [BTN_W-1:0] last_r, last_nxt;
  logic [ACC_W-1:0] ax_r, ay_r, az_r, ax_nxt, ay_nxt, az_nxt;
  logic [UW-1:0] unit_r, unit_nxt;
  logic [7:0] per_r, per_nxt;
  logic rv_r, rv_nxt;
  umr_resp_t rk_r, rk_nxt;
  logic emptied, empty_now, btn_diff, idle_fire, load, has_acc;
  logic [ACC_W-1:0] sx, sy, sz;
  logic [7:0] dz_in;

  always_comb begin
    ep_nxt = ep_r;
    full_nxt = full_r;
    rpt_nxt = rpt_r;
    last_nxt = last_r;
    unit_nxt = unit_r;
    per_nxt = per_r;
    rv_nxt = 1'b0;
    rk_nxt = rk_r;
    len_nxt = wheel_present ? RPT_LEN_WHEEL : RPT_LEN_NOWHEEL; // [RULE15] [RULE16]
    dz_in = wheel_present ? motion.dz : 8'h00;
    sx = motion.valid ? add_sat(ax_r, motion.dx) : ax_r; // [RULE9] [RULE20]
    sy = motion.valid ? add_sat(ay_r, motion.dy) : ay_r;
    sz = motion.valid ? add_sat(az_r, dz_in) : az_r;
    ax_nxt = sx;
    ay_nxt = sy;
    az_nxt = sz;
    emptied = host_ack && ep_r == EP_SENT && full_r; // [RULE21]
    empty_now = !full_r || emptied;
    btn_diff = btn_deb != last_r; // [RULE12]
    has_acc = (|sx) || (|sy) || (|sz);
    idle_fire = idle_r != 8'h00 && unit_r == UNIT_LAST && per_r == idle_r - 8'h01;
    load = cfg && empty_now && (motion.valid || btn_diff || has_acc || idle_fire); // [RULE8] [RULE13]
    if (cfg && !full_r && idle_r != 8'h00) begin
      if (unit_r == UNIT_LAST) begin
        unit_nxt = '0;
        per_nxt = idle_fire ? 8'h00 : per_r + 8'h01;
      end else begin
        unit_nxt = unit_r + 1'b1;
      end
    end
    if (emptied) begin
      full_nxt = 1'b0;
      ep_nxt = EP_READY;
    end
    if (load) begin
      full_nxt = 1'b1;
      rpt_nxt.btn = {BTN_PAD, btn_deb}; // [RULE11] [RULE15]
      rpt_nxt.dx = sat8(sx); // [RULE10] [RULE20]
      rpt_nxt.dy = sat8(sy);
      rpt_nxt.dz = wheel_present ? sat8(sz) : 8'h00; // [RULE16]
      ax_nxt = residue(sx); // [RULE10]
      ay_nxt = residue(sy);
      az_nxt = residue(sz);
      last_nxt = btn_deb; // [RULE11] [RULE13]
      unit_nxt = '0;
      per_nxt = 8'h00;
    end
    if (report_endpoint_poll && cfg) begin
      rv_nxt = 1'b1;
      if (halt_r) begin
        rk_nxt = RSP_STALL; // [RULE5]
      end else if (full_r) begin
        rk_nxt = RSP_DATA; // [RULE4]
        ep_nxt = EP_SENT;
      end else begin
        rk_nxt = RSP_NAK; // [RULE4]
      end
    end
    if (!cfg) begin
      full_nxt = 1'b0; // [RULE7]
      ep_nxt = EP_READY;
      ax_nxt = '0;
      ay_nxt = '0;
      az_nxt = '0;
      unit_nxt = '0;
      per_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ep_r <= EP_READY;
      full_r <= 1'b0;
      rpt_r <= '0;
      len_r <= RPT_LEN_NOWHEEL;
      last_r <= '0;
      ax_r <= '0;
      ay_r <= '0;
      az_r <= '0;
      unit_r <= '0;
      per_r <= 8'h00;
      rv_r <= 1'b0;
      rk_r <= RSP_NONE;
    end else begin
      ep_r <= ep_nxt;
      full_r <= full_nxt;
      rpt_r <= rpt_nxt;
      len_r <= len_nxt;
      last_r <= last_nxt;
      ax_r <= ax_nxt;
      ay_r <= ay_nxt;
      az_r <= az_nxt;
      unit_r <= unit_nxt;
      per_r <= per_nxt;
      rv_r <= rv_nxt;
      rk_r <= rk_nxt;
    end
  end

  assign resp_valid = rv_r;
  assign resp_kind = rk_r;
  assign report = rpt_r;
  assign report_len = len_r;
  assign report_pending = full_r;
  assign report_endpoint_halt = halt_r;
  assign idle_rate = idle_r;
  assign vend_wr = vend_r;
  assign reply_len_valid = rlv_r;
  assign reply_len = rl_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_poll_ignored;
    report_endpoint_poll && !cfg |=> !resp_valid;
  endproperty
  a_poll_ignored: assert property (p_poll_ignored) else $error("poll answered outside configured"); // [RULE4]

  property p_poll_nak;
    report_endpoint_poll && cfg && !halt_r && !full_r |=> resp_valid && resp_kind == RSP_NAK;
  endproperty
  a_poll_nak: assert property (p_poll_nak) else $error("empty poll not NAKed"); // [RULE4]

  property p_stall_only_halt;
    resp_valid && resp_kind == RSP_STALL |-> $past(halt_r);
  endproperty
  a_stall_only_halt: assert property (p_stall_only_halt) else $error("stall without halt"); // [RULE5]

  property p_no_report_unconfig;
    !cfg |=> !report_pending;
  endproperty
  a_no_report_unconfig: assert property (p_no_report_unconfig) else $error("report outside configured"); // [RULE7]

  property p_vendor_write;
    is_vendor |=> vend_wr.valid && vend_wr.addr == $past(setup.idx_lo) && vend_wr.data == $past(setup.idx_hi);
  endproperty
  a_vendor_write: assert property (p_vendor_write) else $error("vendor write lost"); // [RULE2]

  property p_idle_store;
    is_idle |=> idle_rate == $past(setup.val_hi);
  endproperty
  a_idle_store: assert property (p_idle_store) else $error("idle rate not stored"); // [RULE1]

  property p_load_on_motion;
    cfg && !report_pending && motion.valid ##1 cfg |-> report_pending;
  endproperty
  a_load_on_motion: assert property (p_load_on_motion) else $error("motion not loaded"); // [RULE8]

  property p_hold_until_ack;
    report_pending && cfg && !host_ack ##1 cfg |-> report_pending && $stable(report);
  endproperty
  a_hold_until_ack: assert property (p_hold_until_ack) else $error("buffer changed without ack"); // [RULE21]

  property p_report_len;
    $past(rst_n) |-> report_len == ($past(wheel_present) ? RPT_LEN_WHEEL : RPT_LEN_NOWHEEL);
  endproperty
  a_report_len: assert property (p_report_len) else $error("report length wrong"); // [RULE15]

  property p_reply_len_nonzero;
    reply_len_valid |-> reply_len != 16'h0000;
  endproperty
  a_reply_len_nonzero: assert property (p_reply_len_nonzero) else $error("zero byte reply"); // [RULE17]

  property p_button_pad;
    report.btn[7:5] == BTN_PAD;
  endproperty
  a_button_pad: assert property (p_button_pad) else $error("button byte pad not zero"); // [RULE15]

  c_data_sent: cover property (resp_valid && resp_kind == RSP_DATA ##[1:20] host_ack);
  c_stall: cover property (resp_valid && resp_kind == RSP_STALL);
  c_accumulate: cover property (report_pending && motion.valid ##1 report_pending);
  c_vendor: cover property (vend_wr.valid);
endmodule
`default_nettype wire

// [shared/umr_pkg.sv]
// constants and types for the mouse report endpoint
package umr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 8;
  localparam int IDLE_UNIT_NS = 4000000;
  localparam int IDLE_UNIT_CYC = IDLE_UNIT_NS / CLK_NS;
  localparam int DEB_TIME_NS = 32000;
  localparam int DEB_CYC = (DEB_TIME_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // setup request codes
  localparam logic [7:0] RT_VENDOR_OUT = 8'h40;
  localparam logic [7:0] RQ_VENDOR_TEST = 8'h01;
  localparam logic [7:0] RT_CLASS_IF_OUT = 8'h21;
  localparam logic [7:0] RQ_SET_IDLE = 8'h0A;
  localparam logic [7:0] RT_STD_EP_OUT = 8'h02;
  localparam logic [7:0] RQ_CLEAR_FEATURE = 8'h01;
  localparam logic [7:0] RQ_SET_FEATURE = 8'h03;
  localparam logic [7:0] FEAT_EP_HALT = 8'h00;
  localparam logic [7:0] EP_REPORT_IN = 8'h81;
  localparam logic [7:0] RT_STD_DEV_IN = 8'h80;
  localparam logic [7:0] RT_STD_IF_IN = 8'h81;
  localparam logic [7:0] RT_STD_EP_IN = 8'h82;
  localparam logic [7:0] RQ_GET_STATUS = 8'h00;
  localparam logic [7:0] RQ_GET_CONFIG = 8'h08;
  localparam logic [7:0] RQ_GET_IFACE = 8'h0A;
  localparam logic [15:0] STATUS_LEN = 16'h0002;
  localparam logic [15:0] CONFIG_LEN = 16'h0001;
  localparam logic [15:0] IFACE_LEN = 16'h0001;
  localparam logic [15:0] MIN_REPLY_LEN = 16'h0001;
  // ==========================================================
  // report layout and reset values
  localparam int BTN_W = 5;
  localparam int left_button_bit = 0;
  localparam int right_button_bit = 1;
  localparam int middle_button_bit = 2;
  localparam int fourth_button_bit = 3;
  localparam int fifth_button_bit = 4;
  localparam logic [2:0] BTN_PAD = 3'h0;
  localparam logic [2:0] RPT_LEN_WHEEL = 3'h4;
  localparam logic [2:0] RPT_LEN_NOWHEEL = 3'h3;
  localparam logic [7:0] IDLE_RATE_RST = 8'h00;
  localparam logic [7:0] SAT_POS = 8'h7F;
  localparam logic [7:0] SAT_NEG = 8'h80;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    DS_DEFAULT = 2'b00,
    DS_ADDRESSED = 2'b01,
    DS_CONFIGURED = 2'b10
  } umr_dev_state_t;
  typedef enum logic [1:0] {
    RSP_NONE = 2'b00,
    RSP_NAK = 2'b01,
    RSP_DATA = 2'b10,
    RSP_STALL = 2'b11
  } umr_resp_t;
  typedef enum logic {
    EP_READY = 1'b0,
    EP_SENT = 1'b1
  } umr_ep_state_t;
  typedef struct packed {
    logic [7:0] bm_req;
    logic [7:0] b_req;
    logic [7:0] val_lo;
    logic [7:0] val_hi;
    logic [7:0] idx_lo;
    logic [7:0] idx_hi;
    logic [7:0] len_lo;
    logic [7:0] len_hi;
  } umr_setup_t;
  typedef struct packed {
    logic [7:0] btn;
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] dz;
  } umr_report_t;
  typedef struct packed {
    logic valid;
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] dz;
  } umr_motion_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } umr_vend_wr_t;
endpackage

// [src/umr_debounce.sv]
// button debounce filter
`timescale 1ns/1ps
`default_nettype none
module umr_debounce
  import umr_pkg::*;
#(
  parameter int W = BTN_W,
  parameter int CNT = DEB_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);
  localparam int CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CNT - 1);
  logic [W-1:0] stable_r, stable_nxt;
  logic [CW-1:0] cnt_r [W];
  logic [CW-1:0] cnt_nxt [W];

  // ==========================================================
  // per-bit stability counters
  always_comb begin
    stable_nxt = stable_r;
    for (int i = 0; i < W; i++) begin
      cnt_nxt[i] = '0;
      if (raw[i] != stable_r[i]) begin
        if (cnt_r[i] == CNT_LAST) begin
          stable_nxt[i] = raw[i]; // [RULE14]
        end else begin
          cnt_nxt[i] = cnt_r[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stable_r <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      stable_r <= stable_nxt;
      for (int i = 0; i < W; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
    end
  end

  assign stable = stable_r;
endmodule
`default_nettype wire

// [tb/umr_host_model.sv]
// host controller model that polls the report endpoint
`timescale 1ns/1ps
`default_nettype none
module umr_host_model
  import umr_pkg::*;
(
  input wire logic mclk,
  output logic setup_valid,
  output umr_setup_t setup,
  output logic report_endpoint_poll,
  output logic host_ack,
  input wire logic resp_valid,
  input wire umr_resp_t resp_kind
);
  // ==========================================================
  // idle levels
  initial begin
    setup_valid = 1'b0;
    setup = '0;
    report_endpoint_poll = 1'b0;
    host_ack = 1'b0;
  end
  // ==========================================================
  // eight-byte setup packet, bus scrambled once released
  task automatic send(input logic [63:0] pkt);
    @(posedge mclk);
    setup_valid <= 1'b1;
    setup <= pkt;
    @(posedge mclk);
    setup_valid <= 1'b0;
    setup <= ~pkt;
    @(negedge mclk);
  endtask
  // vendor test write, address held inside the legal range
  task automatic vend(input logic [5:0] a, input logic [7:0] d);
    send({RT_VENDOR_OUT, RQ_VENDOR_TEST, 16'h0000, 2'b00, a, d, 16'h0000});
  endtask
  // one IN token; the bench polls only where a scenario checks the answer
  task automatic poll(output logic v, output umr_resp_t k);
    @(posedge mclk);
    report_endpoint_poll <= 1'b1;
    @(posedge mclk);
    report_endpoint_poll <= 1'b0;
    @(negedge mclk);
    v = resp_valid;
    k = resp_kind;
  endtask
  // handshake after a data answer
  task automatic ack;
    @(posedge mclk);
    host_ack <= 1'b1;
    @(posedge mclk);
    host_ack <= 1'b0;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// [tb/test_usb_mouse_report_endpoint.sv]
// self-checking bench for the report endpoint
`timescale 1ns/1ps
`default_nettype none
module test_usb_mouse_report_endpoint
  import umr_pkg::*;
;
  logic mclk, rst_n, wheel_present, setup_valid, report_endpoint_poll, host_ack;
  umr_dev_state_t dev_state;
  umr_setup_t setup;
  umr_motion_t motion;
  logic [BTN_W-1:0] buttons_raw;
  logic resp_valid, report_pending, report_endpoint_halt, reply_len_valid;
  umr_resp_t resp_kind;
  umr_report_t report;
  logic [2:0] report_len;
  logic [7:0] idle_rate;
  umr_vend_wr_t vend_wr;
  logic [15:0] reply_len;
  int mismatches = 0;
  int compares = 0;
  logic v;
  umr_resp_t k;

  umr_report_ep #(.ACC_W(12), .IDLE_UNIT(10), .DEB(3)) u_umr_report_ep (
    .mclk(mclk), .rst_n(rst_n), .wheel_present(wheel_present), .dev_state(dev_state),
    .setup_valid(setup_valid), .setup(setup), .motion(motion), .buttons_raw(buttons_raw),
    .report_endpoint_poll(report_endpoint_poll), .host_ack(host_ack), .resp_valid(resp_valid),
    .resp_kind(resp_kind), .report(report), .report_len(report_len), .report_pending(report_pending),
    .report_endpoint_halt(report_endpoint_halt), .idle_rate(idle_rate), .vend_wr(vend_wr),
    .reply_len_valid(reply_len_valid), .reply_len(reply_len)
  );
  umr_host_model u_umr_host_model (
    .mclk(mclk), .setup_valid(setup_valid), .setup(setup),
    .report_endpoint_poll(report_endpoint_poll), .host_ack(host_ack),
    .resp_valid(resp_valid), .resp_kind(resp_kind)
  );

  // ==========================================================
  // clock and helpers
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    compares++;
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic wait_pend(input int n);
    int i;
    for (i = 0; i < n && report_pending !== 1'b1; i++) @(negedge mclk);
    if (report_pending !== 1'b1) begin
      chk(1'b0, "report never pending");
      conclude();
    end
  endtask
  task automatic mot(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge mclk);
    motion <= {1'b1, x, y, z};
    @(posedge mclk);
    motion <= {1'b0, ~x, ~y, ~z};
    @(negedge mclk);
  endtask
  task automatic take(input logic [31:0] e);
    u_umr_host_model.poll(v, k);
    chk(v === 1'b1 && k === RSP_DATA && report === e, "data answer");
    u_umr_host_model.ack();
  endtask
  task automatic go(input umr_dev_state_t s);
    @(posedge mclk);
    dev_state <= s;
    @(negedge mclk);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_unconf;
    int i;
    u_umr_host_model.poll(v, k);
    chk(v === 1'b0, "poll answered unconfigured");
    mot(8'h05, 8'h05, 8'h00);
    repeat (4) @(negedge mclk);
    chk(report_pending === 1'b0, "report while unconfigured");
    for (i = 0; i < 3; i++) begin
      go(umr_dev_state_t'(i));
      u_umr_host_model.vend(6'h3F - 6'(i), 8'hA5 + 8'(i));
      chk(vend_wr === {1'b1, 8'h3F - 8'(i), 8'hA5 + 8'(i)}, "vendor write");
    end
    go(DS_DEFAULT);
    u_umr_host_model.send({RT_VENDOR_OUT, RQ_VENDOR_TEST, 8'h01, 8'h00, 32'h0});
    chk(vend_wr.valid === 1'b0, "bad vendor pattern taken");
    u_umr_host_model.send({RT_CLASS_IF_OUT, RQ_SET_IDLE, 8'h00, 8'h02, 32'h0});
    chk(idle_rate === 8'h02, "idle rate not stored");
    repeat (40) @(negedge mclk);
    chk(report_pending === 1'b0, "idle report unconfigured");
    go(DS_CONFIGURED);
    repeat (15) @(negedge mclk);
    chk(report_pending === 1'b0, "idle report early");
    wait_pend(10);
    take(32'h0);
    u_umr_host_model.send({RT_CLASS_IF_OUT, RQ_SET_IDLE, 8'h00, 8'h00, 32'h0});
    if (report_pending === 1'b1) take(32'h0);
    repeat (40) @(negedge mclk);
    chk(report_pending === 1'b0, "report without change");
  endtask

  task automatic t_halt;
    u_umr_host_model.poll(v, k);
    chk(v === 1'b1 && k === RSP_NAK, "empty poll not NAK");
    u_umr_host_model.send({RT_STD_EP_OUT, RQ_SET_FEATURE, 16'h0, EP_REPORT_IN, 24'h0});
    u_umr_host_model.poll(v, k);
    chk(v === 1'b1 && report_endpoint_halt === 1'b1 && k === RSP_STALL, "no stall");
    u_umr_host_model.send({RT_STD_EP_OUT, RQ_CLEAR_FEATURE, 16'h0, EP_REPORT_IN, 24'h0});
    u_umr_host_model.poll(v, k);
    chk(v === 1'b1 && k === RSP_NAK, "stall after clear");
  endtask

  task automatic t_accum;
    mot(8'h03, 8'hFE, 8'h01);
    chk(report_pending === 1'b1 && report === 32'h0003FE01, "first load");
    chk(report_len === RPT_LEN_WHEEL, "wheel length");
    mot(8'h64, 8'h9C, 8'h00);
    mot(8'h64, 8'h9C, 8'h00);
    @(posedge mclk);
    buttons_raw <= 5'h01;
    repeat (10) @(negedge mclk);
    chk(report === 32'h0003FE01, "full buffer changed");
    u_umr_host_model.poll(v, k);
    chk(v === 1'b1 && k === RSP_DATA && report === 32'h0003FE01, "first data answer");
    take(32'h0003FE01);
    chk(report_pending === 1'b1 && report === 32'h017F8000, "reload");
    take(32'h017F8000);
    chk(report === 32'h0149B800, "excess kept");
    take(32'h0149B800);
    chk(report_pending === 1'b0, "buffer not emptied");
  endtask

  task automatic t_nowheel;
    @(posedge mclk);
    wheel_present <= 1'b0;
    buttons_raw <= 5'h13;
    @(posedge mclk);
    buttons_raw <= 5'h01;
    repeat (10) @(negedge mclk);
    chk(report_pending === 1'b0, "glitch reported");
    @(posedge mclk);
    buttons_raw <= 5'h00;
    wait_pend(20);
    chk(report === 32'h0 && report_len === RPT_LEN_NOWHEEL, "button load");
    take(32'h0);
    chk(report_pending === 1'b0, "copy not kept");
    mot(8'h01, 8'h02, 8'h09);
    chk(report === 32'h00010200, "wheel byte present");
    take(32'h00010200);
  endtask

  task automatic t_reply;
    logic [63:0] p [4];
    logic [15:0] e [4];
    int i;
    p[0] = {RT_STD_DEV_IN, RQ_GET_STATUS, 48'h0};
    p[1] = {RT_STD_DEV_IN, RQ_GET_CONFIG, 48'h0};
    p[2] = {RT_STD_IF_IN, RQ_GET_IFACE, 48'h0};
    p[3] = {RT_STD_EP_IN, RQ_GET_STATUS, 32'h0, 16'h0500};
    e = '{16'h0001, 16'h0001, 16'h0001, 16'h0002};
    for (i = 0; i < 4; i++) begin
      u_umr_host_model.send(p[i]);
      chk(reply_len_valid === 1'b1 && reply_len === e[i], "reply length");
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    wheel_present = 1'b1;
    dev_state = DS_DEFAULT;
    motion = '0;
    buttons_raw = '0;
    repeat (5) @(negedge mclk);
    chk(report_pending === 1'b0 && idle_rate === IDLE_RATE_RST, "reset values");
    chk(report_len === RPT_LEN_NOWHEEL && resp_kind === RSP_NONE, "reset outputs");
    @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    t_unconf();
    t_halt();
    t_accum();
    t_nowheel();
    t_reply();
    conclude();
  end
endmodule
`default_nettype wire
